// ---- rtl/ssc_consts.vh ----
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// command codes (control1 byte)
`define SSC_CMD_NOP 8'h00
`define SSC_CMD_SM 8'h01
`define SSC_CMD_SD 8'h02
`define SSC_CMD_RO 8'h03
`define SSC_CMD_CR 8'h04
`define SSC_CMD_WR 8'h87
`define SSC_CMD_RR 8'h8E
`define SSC_CMD_WDT 8'h05
`define SSC_CMD_SLEEP_REQUEST_CMD 8'h06
`define SSC_CMD_SLEEP_CONFIRM_CMD 8'h07
`define SSC_CMD_STANDBY_REQUEST_CMD 8'h08
`define SSC_CMD_STANDBY_CONFIRM_CMD 8'h09
// status bit positions
`define SSC_ST_INV 7
`define SSC_ST_PWR_HI 6
`define SSC_ST_PWR_LO 5
`define SSC_ST_SLPREQ 4
`define SSC_ST_STBREQ 3
`define SSC_ST_TEST 2
`define SSC_ST_OSC 1
`define SSC_ST_CRIT 0
// power states
`define SSC_PWR_NORMAL 2'h0
`define SSC_PWR_STANDBY 2'h1
`define SSC_PWR_SLEEP 2'h2
// register addresses
`define SSC_A_ANA 4'h0
`define SSC_A_DAC_LEVEL_CH_A 4'h1
`define SSC_A_GBWA 4'h2
`define SSC_A_DAC_LEVEL_CH_B 4'h3
`define SSC_A_GBWB 4'h4
`define SSC_A_TP 4'h5
`define SSC_A_FAULT 4'h6
`define SSC_A_RST 4'h7
`define SSC_A_REV 4'h8
`define SSC_A_RSVD 4'h9
`define SSC_A_BUFG 4'hA
`define SSC_A_TSLP 4'hB
`define SSC_A_TOFS 4'hC
`define SSC_A_CHEN 4'hD
`define SSC_A_TAMB 4'hE
`define SSC_A_PLS 4'hF
// writable masks
`define SSC_M_ANA 8'hC7
`define SSC_M_GBW 8'hEC
`define SSC_M_TP 8'h37
`define SSC_M_FAULT 8'hFD
`define SSC_M_BUFG 8'h1F
`define SSC_M_CHEN 8'hFE
`define SSC_M_TAMB 8'h03
`define SSC_M_PLS 8'hF3
`define SSC_M_RSTW 8'h01
`define SSC_M_TSLP 8'hF8
`define SSC_M_TOFS 8'h3F
`define SSC_M_FULL 8'hFF
// reset values
`define SSC_R_ANA 8'h85
`define SSC_R_DAC 8'h00
`define SSC_R_GBW 8'h04
`define SSC_R_TP 8'h33
`define SSC_R_BUFG 8'h1A
`define SSC_R_CHEN 8'h00
`define SSC_R_TAMB 8'h00
`define SSC_R_PLS 8'h00
`define SSC_R_RST 8'h09
`define SSC_R_ZERO 8'h00
// fields
`define SSC_F_VLOW_HI 7
`define SSC_F_VLOW_LO 6
`define SSC_F_TDC_HI 2
`define SSC_F_TDC_LO 1
`define SSC_F_UNITY 0
`define SSC_F_GAIN_HI 7
`define SSC_F_GAIN_LO 5
`define SSC_F_BW_HI 3
`define SSC_F_BW_LO 2
`define SSC_F_POR 0
// dc lead times in us
`define SSC_TDC0_US 50
`define SSC_TDC1_US 100
`define SSC_TDC2_US 200
`define SSC_TDC3_US 400
`define SSC_CLK_MHZ 100
`define SSC_LEAD_W 16
`endif

// ---- rtl/ssc_lead_timer.v ----
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
// dc lead delay: counts selected time after start pulse
module ssc_lead_timer (
    // clock
    input wire clk,
    input wire srst,
    input wire ce,
    // control
    input wire start,
    input wire [1:0] sel,
    // status
    output reg busy_ff,
    output reg done_ff
);
    localparam [31:0] C0W = `SSC_TDC0_US * `SSC_CLK_MHZ;
    localparam [31:0] C1W = `SSC_TDC1_US * `SSC_CLK_MHZ;
    localparam [31:0] C2W = `SSC_TDC2_US * `SSC_CLK_MHZ;
    localparam [31:0] C3W = `SSC_TDC3_US * `SSC_CLK_MHZ;
    localparam [15:0] C0 = C0W[15:0];
    localparam [15:0] C1 = C1W[15:0];
    localparam [15:0] C2 = C2W[15:0];
    localparam [15:0] C3 = C3W[15:0];
    reg [15:0] cnt_ff;
    reg [15:0] len;
    always @* begin
        case (sel)
            2'h0: len = C0;
            2'h1: len = C1;
            2'h2: len = C2;
            default: len = C3;
        endcase
    end
    always @(posedge clk) begin
        if (srst) begin
            cnt_ff <= 16'h0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (start) begin
                cnt_ff <= len - 16'h0001;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (cnt_ff == 16'h0000) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ssc_reg_mem.v ----
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
// plain 16x8 store with per-bit write mask, registered read
module ssc_reg_mem (
    // clock
    input wire clk,
    input wire srst,
    input wire ce,
    // write port
    input wire wr_en,
    input wire [3:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [7:0] wr_mask,
    // read port
    input wire [3:0] rd_addr,
    output reg [7:0] rd_data_ff,
    // all contents flat
    output wire [127:0] flat
);
    reg [7:0] mem_ff [0:15];
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_w
            assign flat[gi*8 +: 8] = mem_ff[gi];
            always @(posedge clk) begin
                if (srst) begin
                    mem_ff[gi] <= `SSC_R_ZERO;
                end else if (ce && wr_en && wr_addr == gi) begin
                    mem_ff[gi] <= (mem_ff[gi] & ~wr_mask) |
                                  (wr_data & wr_mask);
                end
            end
        end
    endgenerate
    always @(posedge clk) begin
        if (srst) begin
            rd_data_ff <= `SSC_R_ZERO;
        end else if (ce) begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ssc_status_regs.v ----
// Behaviour
// - invalid command sets status bit 7; next valid command clears it
// - unknown codes and bad parity on measure, diag, write are invalid
// - while result ready is low, any command but chip reset is invalid
// - readout command with result ready low is always invalid
// - writing a one to any fault source bit but bit 1 is invalid
// - watchdog service in sleep is invalid
// - sleep request command raises status bit 4
// - sleep confirm clears request, enters sleep, updates bits 6 and 5
// - standby request raises bit 3; standby confirm enters standby
// - bit 2 shows test mode; chip reset leaves test mode unless the test input is still high
// - bit 1 high while internal oscillator is enabled
// - any monitored node but node 1 out of range sets status bit 0
// - critical error stays while any fault source bit is set
// - fault bits may come up set after reset or wake-up
// - sixteen 8-bit registers at addresses 0 to 15
// - unimplemented bits read as zero and ignore writes
// - two-bit low supply field selects the low-battery threshold
// - two-bit dc lead field selects 50, 100, 200 or 400 us
// - buffer bypass bit selects adc path during active light only
// - dac level registers at 1 and 3, fully writable, reset zero
// - three-bit gain field per channel in bits 7 to 5
// - two-bit bandwidth field in bits 3 and 2, reset code 01
// - fault source register accepts only writes of zero outside bit 1
// - bad write parity leaves every register unchanged
// - status byte is first data byte of a register read
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_status_regs (
    // clock
    input wire clk,
    input wire srst,
    input wire ce,
    // decoded command from the serial front end
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [7:0] cmd_arg1,
    input wire [7:0] cmd_arg2,
    input wire cmd_parity_ok,
    // analog and pin inputs (asynchronous)
    input wire result_ready_pin,
    input wire [7:0] node_fault_in,
    input wire test_mode_in,
    input wire active_light_in,
    // status and read data
    output wire [7:0] status_byte,
    output reg [7:0] rd_data_ff,
    output reg rd_valid_ff,
    output reg chip_reset_ff,
    // configuration to analog
    output wire [1:0] low_supply_threshold_sel,
    output wire [1:0] dc_lead_sel,
    output wire adc_buffer_bypass,
    output wire [7:0] dac_level_ch_a,
    output wire [7:0] dac_level_ch_b,
    output wire [2:0] gain_sel_ch_a,
    output wire [2:0] gain_sel_ch_b,
    output wire [1:0] bandwidth_sel_ch_a,
    output wire [1:0] bandwidth_sel_ch_b,
    output wire [127:0] cfg_flat,
    output wire osc_enable,
    output wire dc_lead_busy,
    output wire dc_lead_done
);
    // synchronisers for the test mode, result ready and node fault inputs
    reg [9:0] sync1_ff;
    reg [9:0] sync2_ff;
    always @(posedge clk) begin
        if (srst) begin
            sync1_ff <= 10'h000;
            sync2_ff <= 10'h000;
        end else if (ce) begin
            sync1_ff <= {test_mode_in, result_ready_pin, node_fault_in};
            sync2_ff <= sync1_ff;
        end
    end
    wire [7:0] node_fault = sync2_ff[7:0];
    wire rdy = sync2_ff[8];
    wire test_in = sync2_ff[9];

    function [7:0] wmask;
        input [3:0] a;
        begin
            case (a)
                `SSC_A_ANA: wmask = `SSC_M_ANA;
                `SSC_A_DAC_LEVEL_CH_A: wmask = `SSC_M_FULL;
                `SSC_A_GBWA: wmask = `SSC_M_GBW;
                `SSC_A_DAC_LEVEL_CH_B: wmask = `SSC_M_FULL;
                `SSC_A_GBWB: wmask = `SSC_M_GBW;
                `SSC_A_TP: wmask = `SSC_M_TP;
                `SSC_A_RST: wmask = `SSC_M_RSTW;
                `SSC_A_BUFG: wmask = `SSC_M_BUFG;
                `SSC_A_CHEN: wmask = `SSC_M_CHEN;
                `SSC_A_TAMB: wmask = `SSC_M_TAMB;
                `SSC_A_PLS: wmask = `SSC_M_PLS;
                default: wmask = `SSC_R_ZERO;
            endcase
        end
    endfunction

    function is_known;
        input [7:0] c;
        begin
            case (c)
                `SSC_CMD_NOP, `SSC_CMD_SM, `SSC_CMD_SD, `SSC_CMD_RO,
                `SSC_CMD_CR, `SSC_CMD_WR, `SSC_CMD_RR, `SSC_CMD_WDT,
                `SSC_CMD_SLEEP_REQUEST_CMD, `SSC_CMD_SLEEP_CONFIRM_CMD, `SSC_CMD_STANDBY_REQUEST_CMD,
                `SSC_CMD_STANDBY_CONFIRM_CMD: is_known = 1'b1;
                default: is_known = 1'b0;
            endcase
        end
    endfunction

    // state
    reg inv_ff;
    reg slpreq_ff;
    reg stbreq_ff;
    reg [1:0] pwr_ff;
    reg test_ff;
    reg [7:0] fault_ff;
    reg [7:0] rstc_ff;

    wire is_wr = cmd_code == `SSC_CMD_WR;
    wire [3:0] wr_addr = cmd_arg2[7:4];
    wire par_cmd = is_wr || cmd_code == `SSC_CMD_SM ||
                   cmd_code == `SSC_CMD_SD;
    wire fault_one = is_wr && wr_addr == `SSC_A_FAULT &&
                     (cmd_arg1 & `SSC_M_FAULT) != `SSC_R_ZERO;
    wire in_sleep = pwr_ff == `SSC_PWR_SLEEP;
    wire is_cr = cmd_code == `SSC_CMD_CR;

    reg bad;
    always @* begin
        bad = 1'b0;
        if (!is_known(cmd_code)) bad = 1'b1;
        if (par_cmd && !cmd_parity_ok) bad = 1'b1;
        if (!rdy && !is_cr) bad = 1'b1;
        if (cmd_code == `SSC_CMD_RO && !rdy) bad = 1'b1;
        if (fault_one) bad = 1'b1;
        if (cmd_code == `SSC_CMD_WDT && in_sleep) bad = 1'b1;
    end
    wire ok = cmd_valid && !bad;
    // a bad write never reaches any register
    wire do_wr = ok && is_wr;

    wire [127:0] mem_flat;
    wire [7:0] mem_rd;
    ssc_reg_mem u_mem (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .wr_en(do_wr && wr_addr != `SSC_A_FAULT && wr_addr != `SSC_A_RST),
        .wr_addr(wr_addr),
        // memory holds value xor reset value, so store the data the same way
        .wr_data(cmd_arg1 ^ rstv(wr_addr)),
        .wr_mask(wmask(wr_addr)),
        .rd_addr(cmd_arg1[7:4]),
        .rd_data_ff(mem_rd),
        .flat(mem_flat)
    );

    // reset values live in an xor overlay so the memory can clear to zero
    function [7:0] rstv;
        input [3:0] a;
        begin
            case (a)
                `SSC_A_ANA: rstv = `SSC_R_ANA;
                `SSC_A_GBWA: rstv = `SSC_R_GBW;
                `SSC_A_GBWB: rstv = `SSC_R_GBW;
                `SSC_A_TP: rstv = `SSC_R_TP;
                `SSC_A_BUFG: rstv = `SSC_R_BUFG;
                default: rstv = `SSC_R_ZERO;
            endcase
        end
    endfunction

    wire [127:0] reg_flat;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_r
            localparam [31:0] IDX = gi;
            assign reg_flat[gi*8 +: 8] = mem_flat[gi*8 +: 8] ^
                                         rstv(IDX[3:0]);
        end
    endgenerate
    assign cfg_flat = reg_flat;

    wire [7:0] ana = reg_flat[`SSC_A_ANA*8 +: 8];
    wire [7:0] gbwa = reg_flat[`SSC_A_GBWA*8 +: 8];
    wire [7:0] gbwb = reg_flat[`SSC_A_GBWB*8 +: 8];
    assign low_supply_threshold_sel = ana[`SSC_F_VLOW_HI:`SSC_F_VLOW_LO];
    assign dc_lead_sel = ana[`SSC_F_TDC_HI:`SSC_F_TDC_LO];
    assign adc_buffer_bypass = active_light_in & ana[`SSC_F_UNITY];
    assign dac_level_ch_a = reg_flat[`SSC_A_DAC_LEVEL_CH_A*8 +: 8];
    assign dac_level_ch_b = reg_flat[`SSC_A_DAC_LEVEL_CH_B*8 +: 8];
    assign gain_sel_ch_a = gbwa[`SSC_F_GAIN_HI:`SSC_F_GAIN_LO];
    assign gain_sel_ch_b = gbwb[`SSC_F_GAIN_HI:`SSC_F_GAIN_LO];
    assign bandwidth_sel_ch_a = gbwa[`SSC_F_BW_HI:`SSC_F_BW_LO];
    assign bandwidth_sel_ch_b = gbwb[`SSC_F_BW_HI:`SSC_F_BW_LO];
    // oscillator stops only in sleep
    assign osc_enable = !in_sleep;

    ssc_lead_timer u_lead (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .start(ok && cmd_code == `SSC_CMD_SM),
        .sel(dc_lead_sel),
        .busy_ff(dc_lead_busy),
        .done_ff(dc_lead_done)
    );

    // invalid flag, power state, requests, test mode
    always @(posedge clk) begin
        if (srst) begin
            inv_ff <= 1'b0;
            slpreq_ff <= 1'b0;
            stbreq_ff <= 1'b0;
            pwr_ff <= `SSC_PWR_NORMAL;
            test_ff <= 1'b0;
            chip_reset_ff <= 1'b0;
        end else if (ce) begin
            chip_reset_ff <= 1'b0;
            if (test_in) test_ff <= 1'b1;
            if (cmd_valid) begin
                inv_ff <= bad;
                if (ok) begin
                    case (cmd_code)
                        `SSC_CMD_SLEEP_REQUEST_CMD: slpreq_ff <= 1'b1;
                        `SSC_CMD_SLEEP_CONFIRM_CMD: if (slpreq_ff) begin
                            slpreq_ff <= 1'b0;
                            pwr_ff <= `SSC_PWR_SLEEP;
                        end
                        `SSC_CMD_STANDBY_REQUEST_CMD: stbreq_ff <= 1'b1;
                        `SSC_CMD_STANDBY_CONFIRM_CMD: if (stbreq_ff) begin
                            stbreq_ff <= 1'b0;
                            pwr_ff <= `SSC_PWR_STANDBY;
                        end
                        `SSC_CMD_CR: begin
                            test_ff <= test_in;
                            slpreq_ff <= 1'b0;
                            stbreq_ff <= 1'b0;
                            pwr_ff <= `SSC_PWR_NORMAL;
                            chip_reset_ff <= 1'b1;
                        end
                        `SSC_CMD_NOP: ;
                        `SSC_CMD_RR: ;
                        `SSC_CMD_WR: ;
                        default: if (pwr_ff != `SSC_PWR_NORMAL)
                            pwr_ff <= `SSC_PWR_NORMAL;
                    endcase
                end
            end
        end
    end

    // fault source: set by nodes, cleared by zero writes; set wins
    wire fault_wr = do_wr && wr_addr == `SSC_A_FAULT;
    wire [7:0] fault_keep = fault_wr ? (fault_ff & cmd_arg1) : fault_ff;
    always @(posedge clk) begin
        if (srst) begin
            fault_ff <= `SSC_R_ZERO;
        end else if (ce) begin
            // monitored nodes load straight in, also right after reset
            fault_ff <= (fault_keep | node_fault) & `SSC_M_FAULT;
        end
    end

    // reset cause: por bit takes the written value, so writing zero clears it and writing one sets it
    always @(posedge clk) begin
        if (srst) begin
            rstc_ff <= `SSC_R_RST;
        end else if (ce && do_wr && wr_addr == `SSC_A_RST) begin
            rstc_ff[`SSC_F_POR] <= cmd_arg1[`SSC_F_POR];
        end
    end

    assign status_byte = {inv_ff, pwr_ff, slpreq_ff, stbreq_ff, test_ff,
                          osc_enable, fault_ff != `SSC_R_ZERO};

    // register read: status byte first, then target data
    reg rd_pend_ff;
    reg [3:0] rd_addr_ff;
    always @(posedge clk) begin
        if (srst) begin
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= 4'h0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= `SSC_R_ZERO;
        end else if (ce) begin
            rd_pend_ff <= ok && cmd_code == `SSC_CMD_RR;
            rd_addr_ff <= cmd_arg1[7:4];
            rd_valid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                case (rd_addr_ff)
                    `SSC_A_FAULT: rd_data_ff <= fault_ff;
                    `SSC_A_RST: rd_data_ff <= rstc_ff;
                    `SSC_A_TSLP, `SSC_A_TOFS, `SSC_A_REV, `SSC_A_RSVD:
                        rd_data_ff <= `SSC_R_ZERO;
                    default: rd_data_ff <= mem_rd ^ rstv(rd_addr_ff);
                endcase
            end
        end
    end
    // status byte is driven continuously for the first shifted byte
endmodule
`default_nettype wire

// ---- tb/ssc_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_master_model (
    // clock
    input wire logic clk,
    // command toward the device
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_arg1,
    output logic [7:0] cmd_arg2,
    output logic cmd_parity_ok
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h5A;
        cmd_arg1 = 8'hA5;
        cmd_arg2 = 8'h5A;
        cmd_parity_ok = 1'b0;
    end
    // one whole command per cycle; afterwards the lines are inverted so a
    // stale value can never pass for a live command
    task automatic send(input logic [7:0] c, input logic [7:0] a1,
                        input logic [7:0] a2, input logic pok);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_arg1 <= a1;
        cmd_arg2 <= a2;
        cmd_parity_ok <= pok;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        cmd_arg1 <= ~a1;
        cmd_arg2 <= ~a2;
        cmd_parity_ok <= ~pok;
    endtask
endmodule
`default_nettype wire

// ---- tb/ssc_status_regs_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_status_regs_chk (
    // clock
    input wire clk,
    input wire srst,
    input wire ce,
    // command
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire cmd_parity_ok,
    // pins
    input wire result_ready_pin,
    input wire [7:0] node_fault_in,
    input wire active_light_in,
    // outputs
    input wire [7:0] status_byte,
    input wire rd_valid_ff,
    input wire adc_buffer_bypass,
    input wire osc_enable,
    input wire chip_reset_ff
);
    // the ready pin passes a two-stage sync, so judge it by its history
    reg [3:0] rdy_hist_ff;
    wire take;
    wire rdy_hi;
    wire rdy_lo;
    wire known;
    always @(posedge clk) begin
        rdy_hist_ff <= {rdy_hist_ff[2:0], result_ready_pin};
    end
    assign take = ce && cmd_valid;
    assign rdy_hi = (rdy_hist_ff == 4'hF) && result_ready_pin;
    assign rdy_lo = (rdy_hist_ff == 4'h0) && !result_ready_pin;
    assign known = cmd_code inside {`SSC_CMD_NOP, `SSC_CMD_SM, `SSC_CMD_SD,
        `SSC_CMD_RO, `SSC_CMD_CR, `SSC_CMD_WR, `SSC_CMD_RR, `SSC_CMD_WDT,
        `SSC_CMD_SLEEP_REQUEST_CMD, `SSC_CMD_SLEEP_CONFIRM_CMD, `SSC_CMD_STANDBY_REQUEST_CMD, `SSC_CMD_STANDBY_CONFIRM_CMD};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_unknown_code_inv: assert property (take && !known |=>
        status_byte[7]) else $error("unknown command not flagged");
    a_bad_parity_inv: assert property (take && !cmd_parity_ok &&
        cmd_code inside {`SSC_CMD_SM, `SSC_CMD_SD, `SSC_CMD_WR}
        |=> status_byte[7]) else $error("bad parity not flagged");
    a_busy_cmd_inv: assert property (take && rdy_lo &&
        cmd_code != `SSC_CMD_CR |=> status_byte[7])
        else $error("command while busy not flagged");
    a_valid_clears_inv: assert property (take && rdy_hi &&
        cmd_code == `SSC_CMD_NOP |=> !status_byte[7])
        else $error("valid command left invalid flag");
    a_sleep_req_flag: assert property (take && rdy_hi &&
        cmd_code == `SSC_CMD_SLEEP_REQUEST_CMD |=> status_byte[4])
        else $error("sleep request flag not raised");
    a_sleep_confirm: assert property (take && rdy_hi && status_byte[4] &&
        cmd_code == `SSC_CMD_SLEEP_CONFIRM_CMD |=> !status_byte[4] &&
        status_byte[6:5] == `SSC_PWR_SLEEP) else $error("sleep not entered");
    a_stby_confirm: assert property (take && rdy_hi && status_byte[3] &&
        cmd_code == `SSC_CMD_STANDBY_CONFIRM_CMD |=> !status_byte[3] &&
        status_byte[6:5] == `SSC_PWR_STANDBY) else $error("no standby");
    a_wdt_sleep_inv: assert property (take && rdy_hi &&
        cmd_code == `SSC_CMD_WDT && status_byte[6:5] == `SSC_PWR_SLEEP
        |=> status_byte[7]) else $error("watchdog in sleep not flagged");
    a_osc_flag: assert property (osc_enable ==
        (status_byte[6:5] != `SSC_PWR_SLEEP))
        else $error("oscillator state differs from power state");
    a_cr_pulse: assert property (take && cmd_code == `SSC_CMD_CR |=>
        chip_reset_ff ##1 !chip_reset_ff)
        else $error("chip reset pulse wrong");
    a_crit_on_fault: assert property (((node_fault_in & 8'hFD) != 8'h00)
        [*5] |-> status_byte[0]) else $error("fault without crit");
    a_rr_answer: assert property (take && rdy_hi &&
        cmd_code == `SSC_CMD_RR |-> ##2 rd_valid_ff)
        else $error("read answer late");
    a_bypass_gate: assert property (!active_light_in |->
        !adc_buffer_bypass) else $error("bypass outside active light");
endmodule
bind ssc_status_regs ssc_status_regs_chk u_chk (.clk(clk), .srst(srst),
    .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_parity_ok(cmd_parity_ok), .result_ready_pin(result_ready_pin),
    .node_fault_in(node_fault_in), .active_light_in(active_light_in),
    .status_byte(status_byte), .rd_valid_ff(rd_valid_ff),
    .adc_buffer_bypass(adc_buffer_bypass), .osc_enable(osc_enable),
    .chip_reset_ff(chip_reset_ff));
`default_nettype wire

// ---- tb/tb_ssc_status_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
module tb_ssc_status_regs;
    typedef struct packed {
        logic [7:0] code, a1, a2;
        logic pok, inv;
    } ssc_row_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdat, rexp;
    } ssc_wrow_t;
    logic clk = 1'b0, srst = 1'b1, rdy = 1'b1, tmode = 1'b0, light = 1'b0;
    logic [7:0] fault = 8'h00;
    logic cv, pok;
    logic [7:0] code, a1, a2, st, rdat, dac_a, dac_b;
    logic [1:0] vlow, lead, bw_a, bw_b;
    logic [2:0] g_a, g_b;
    logic bypass, osc, lbusy, ldone;
    logic [127:0] cfg;
    int err_count = 0, compares = 0, cyc = 0;
    ssc_row_t rows[12];
    ssc_wrow_t wrows[10];
    always #5 clk = ~clk;
    ssc_master_model m (.clk(clk), .cmd_valid(cv), .cmd_code(code),
        .cmd_arg1(a1), .cmd_arg2(a2), .cmd_parity_ok(pok));
    ssc_status_regs dut (.clk(clk), .srst(srst), .ce(1'b1), .cmd_valid(cv),
        .cmd_code(code), .cmd_arg1(a1), .cmd_arg2(a2), .cmd_parity_ok(pok),
        .result_ready_pin(rdy), .node_fault_in(fault), .test_mode_in(tmode),
        .active_light_in(light), .status_byte(st), .rd_data_ff(rdat),
        .rd_valid_ff(), .chip_reset_ff(), .low_supply_threshold_sel(vlow),
        .dc_lead_sel(lead), .adc_buffer_bypass(bypass),
        .dac_level_ch_a(dac_a), .dac_level_ch_b(dac_b), .gain_sel_ch_a(g_a),
        .gain_sel_ch_b(g_b), .bandwidth_sel_ch_a(bw_a),
        .bandwidth_sel_ch_b(bw_b), .cfg_flat(cfg), .osc_enable(osc),
        .dc_lead_busy(lbusy), .dc_lead_done(ldone));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] x,
                       input logic [7:0] y, input logic p);
        m.send(c, x, y, p);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        cmd(`SSC_CMD_RR, {a, 4'h0}, 8'h00, 1'b1);
        check(rdat, exp);
    endtask
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        rows = '{'{8'h00, 8'h00, 8'h00, 1, 0}, '{8'h55, 8'h00, 8'h00, 1, 1},
            '{8'h00, 8'h00, 8'h00, 1, 0}, '{`SSC_CMD_SM, 8'h00, 8'h00, 0, 1},
            '{`SSC_CMD_SD, 8'h00, 8'h00, 0, 1}, '{`SSC_CMD_WR, 8'h5A, 8'h10,
            0, 1}, '{`SSC_CMD_WR, 8'h01, 8'h60, 1, 1}, '{`SSC_CMD_WR, 8'h00,
            8'h60, 1, 0}, '{`SSC_CMD_RO, 8'h00, 8'h00, 1, 0}, '{`SSC_CMD_RR,
            8'h00, 8'h00, 1, 0}, '{`SSC_CMD_WDT, 8'h00, 8'h00, 1, 0},
            '{8'hFF, 8'h00, 8'h00, 1, 1}};
        wrows = '{'{4'h1, 8'hA5, 8'hA5}, '{4'h2, 8'hFF, 8'hEC},
            '{4'h3, 8'h3C, 8'h3C}, '{4'h4, 8'hA8, 8'hA8},
            '{4'h0, 8'hFF, 8'hC7}, '{4'hD, 8'hFF, 8'hFE},
            '{4'hE, 8'hFF, 8'h03}, '{4'hF, 8'hFF, 8'hF3},
            '{4'hA, 8'hFF, 8'h1F}, '{4'h5, 8'hFF, 8'h37}};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        settle();
        check(st, 8'h02);
        foreach (rows[i]) begin
            cmd(rows[i].code, rows[i].a1, rows[i].a2, rows[i].pok);
            check(st[7], rows[i].inv);
        end
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h85);
        rd(4'h2, 8'h04);
        rd(4'h3, 8'h00);
        rd(4'h4, 8'h04);
        foreach (wrows[i]) begin
            cmd(`SSC_CMD_WR, wrows[i].wdat, {wrows[i].addr, 4'h0}, 1'b1);
            rd(wrows[i].addr, wrows[i].rexp);
        end
        check({dac_a, dac_b}, 16'hA53C);
        check(cfg[15:8], 8'hA5);
        check({g_a, bw_a, g_b, bw_b}, 10'h3F6);
        check({vlow, lead}, 4'hF);
        check(bypass, 1'b0);
        @(posedge clk);
        light <= 1'b1;
        #1;
        check(bypass, 1'b1);
        cmd(`SSC_CMD_WR, 8'h42, 8'h00, 1'b1);
        check({vlow, lead, bypass}, 5'h0A);
        cmd(`SSC_CMD_SM, 8'h00, 8'h00, 1'b1);
        check({st[7], lbusy}, 2'h1);
        repeat (`SSC_TDC1_US * `SSC_CLK_MHZ - 4) @(posedge clk);
        #1;
        check({lbusy, ldone}, 2'h2);
        @(posedge clk);
        #1;
        check({lbusy, ldone}, 2'h1);
        @(posedge clk);
        fault <= 8'h02;
        settle();
        check(st[0], 1'b0);
        @(posedge clk);
        fault <= 8'h01;
        settle();
        cmd(`SSC_CMD_WR, 8'h00, 8'h60, 1'b1);
        check(st[0], 1'b1);
        rd(4'h6, 8'h01);
        @(posedge clk);
        fault <= 8'h00;
        settle();
        cmd(`SSC_CMD_WR, 8'h00, 8'h60, 1'b1);
        check({st[7], st[0]}, 2'h0);
        @(posedge clk);
        tmode <= 1'b1;
        settle();
        check(st[2], 1'b1);
        check({st[1], osc}, 2'h3);
        @(posedge clk);
        tmode <= 1'b0;
        cmd(`SSC_CMD_SLEEP_REQUEST_CMD, 8'h00, 8'h00, 1'b1);
        check(st[4], 1'b1);
        cmd(`SSC_CMD_SLEEP_CONFIRM_CMD, 8'h00, 8'h00, 1'b1);
        check(st[6:4], 3'h4);
        check({st[1], osc}, 2'h0);
        cmd(`SSC_CMD_WDT, 8'h00, 8'h00, 1'b1);
        check(st[7], 1'b1);
        cmd(`SSC_CMD_STANDBY_REQUEST_CMD, 8'h00, 8'h00, 1'b1);
        check({st[7], st[3]}, 2'h1);
        cmd(`SSC_CMD_STANDBY_CONFIRM_CMD, 8'h00, 8'h00, 1'b1);
        check(st[6:3], 4'h4);
        cmd(`SSC_CMD_NOP, 8'h00, 8'h00, 1'b1);
        check(st[6:5], `SSC_PWR_STANDBY);
        cmd(`SSC_CMD_WDT, 8'h00, 8'h00, 1'b1);
        check(st[7:5], {1'b0, `SSC_PWR_NORMAL});
        @(posedge clk);
        rdy <= 1'b0;
        settle();
        cmd(`SSC_CMD_NOP, 8'h00, 8'h00, 1'b1);
        check(st[7], 1'b1);
        cmd(`SSC_CMD_CR, 8'h00, 8'h00, 1'b1);
        check({st[7], st[2]}, 2'h0);
        cmd(`SSC_CMD_RO, 8'h00, 8'h00, 1'b1);
        check(st[7], 1'b1);
        @(posedge clk);
        rdy <= 1'b1;
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        settle();
        check(st, 8'h02);
        rd(4'h1, 8'h00);
        tally_and_finish;
    end
endmodule
`default_nettype wire
